// ---- core/tpg_gate_ctrl.sv ----
`default_nettype none
// Notes on behaviour
// - register gate mode: high bit alone drives high, low alone drives low, else both low
// - six-input mode: each input drives its own gate unless both inputs of that phase are high
// - six-input mode, both inputs high: both gates low; shoot-through fault flag set if shoot-through mode selected
// - six-input, dead-time monitor setting: insert dead time if both-low gap too short
// - other modes use the same gap check: dead time added only if both-low gap too short
// - on any switching, strong pull-down on opposite gate for programmed time
// - fault or off pin pulls all gate outputs low
// - off pin high overrides inputs directly by masking gate outputs; phase state keeps running
// - pump undervoltage flag set at power-up, held until clear-fault command
// - sense amp output disabled after reset until software enables it
// - sense amp gain selectable among nine settings
// - sense amp offset selects half or eighth of reference
// - sleep engages semi-active pull-down on low-side gates
// - cleared phase drive enable forces both gates of that phase low
// - mode 010: three-input with register phase enable, low inputs unused
module tpg_gate_ctrl #(
    parameter int NPH = 3,
    parameter int CNT_W = tpg_pkg::CNT_W,
    parameter int DEAD_CYC = tpg_pkg::DEAD_CYC,
    parameter int STRONG_PD_CYC = tpg_pkg::STRONG_PD_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [NPH-1:0] high_side_pwm_in_i,
    input wire logic [NPH-1:0] low_side_pwm_in_i,
    input wire logic external_off_pin_i,
    input wire logic sleep_n_i,
    input wire logic fault_i,
    input wire logic [2:0] pwm_mode_i,
    input wire logic shoot_through_mode_sel_i,
    input wire logic dead_time_mode_sel_i,
    input wire logic [1:0] six_input_dead_time_sel_i,
    input wire logic [NPH-1:0] phase_drive_enable_i,
    input wire logic [NPH-1:0] reg_high_gate_cmd_i,
    input wire logic [NPH-1:0] reg_low_gate_cmd_i,
    input wire logic [CNT_W-1:0] strong_pulldown_time_i,
    input wire logic clear_fault_cmd_i,
    input wire logic gate_supply_softstart_off_i,
    input wire logic csa_enable_set_i,
    input wire logic [3:0] csa_gain_i,
    input wire logic csa_offset_i,
    input wire logic csa_cfg_we_i,
    output logic [NPH-1:0] high_gate_out_o,
    output logic [NPH-1:0] low_gate_out_o,
    output logic [NPH-1:0] strong_pd_high_o,
    output logic [NPH-1:0] strong_pd_low_o,
    output logic [NPH-1:0] semi_active_pd_o,
    output logic [NPH-1:0] shoot_through_fault_o,
    output logic pump_undervoltage_flag_o,
    output logic gate_supply_softstart_off_o,
    output logic current_sense_amp_en_o,
    output logic [3:0] current_sense_amp_gain_o,
    output logic current_sense_amp_offset_o
);
    // ****************************************
    // mode decode
    // ****************************************
    logic [NPH-1:0] want_high;
    logic [NPH-1:0] want_low;
    logic [NPH-1:0] st_hit;
    logic [NPH-1:0] core_high;
    logic [NPH-1:0] core_low;
    logic six_mode;
    logic dt_always;
    logic kill_all;

    assign six_mode = (pwm_mode_i == tpg_pkg::PWM_MODE_6X);
    assign dt_always = !six_mode || dead_time_mode_sel_i
        || (six_input_dead_time_sel_i != tpg_pkg::SIX_DT_MONITOR);
    assign kill_all = fault_i || !sleep_n_i;

    always_comb begin
        want_high = '0;
        want_low = '0;
        st_hit = '0;
        for (int p = 0; p < NPH; p++) begin
            if (pwm_mode_i == tpg_pkg::PWM_MODE_REG_GATE) begin
                want_high[p] = reg_high_gate_cmd_i[p] && !reg_low_gate_cmd_i[p];
                want_low[p] = reg_low_gate_cmd_i[p] && !reg_high_gate_cmd_i[p];
            end else if (pwm_mode_i == tpg_pkg::PWM_MODE_3X_REG) begin
                want_high[p] = high_side_pwm_in_i[p];
                want_low[p] = !high_side_pwm_in_i[p];
            end else if (pwm_mode_i == tpg_pkg::PWM_MODE_3X_PIN) begin
                want_high[p] = low_side_pwm_in_i[p] && high_side_pwm_in_i[p];
                want_low[p] = low_side_pwm_in_i[p] && !high_side_pwm_in_i[p];
            end else begin
                st_hit[p] = high_side_pwm_in_i[p] && low_side_pwm_in_i[p];
                want_high[p] = high_side_pwm_in_i[p] && !st_hit[p];
                want_low[p] = low_side_pwm_in_i[p] && !st_hit[p];
            end
            if (!phase_drive_enable_i[p]) begin
                want_high[p] = 1'b0;
                want_low[p] = 1'b0;
            end
        end
    end

    // ****************************************
    // per-phase drivers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NPH; g++) begin : g_ph
            tpg_phase #(
                .CNT_W(CNT_W)
            ) u_phase (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .want_high_i(want_high[g]),
                .want_low_i(want_low[g]),
                .dt_always_i(dt_always),
                .dead_cyc_i(CNT_W'(DEAD_CYC)),
                .strong_cyc_i(strong_pulldown_time_i),
                .kill_i(kill_all),
                .high_gate_out_o(core_high[g]),
                .low_gate_out_o(core_low[g]),
                .strong_pd_high_o(strong_pd_high_o[g]),
                .strong_pd_low_o(strong_pd_low_o[g])
            );
        end
    endgenerate

    // off pin bypasses the registered path, gates go low at once
    assign high_gate_out_o = core_high & {NPH{!external_off_pin_i}};
    assign low_gate_out_o = core_low & {NPH{!external_off_pin_i}};
    assign semi_active_pd_o = {NPH{!sleep_n_i}};

    // ****************************************
    // latched flags
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shoot_through_fault_o <= '0;
        end else begin
            // new event wins over clear
            shoot_through_fault_o <= (clear_fault_cmd_i ? '0 : shoot_through_fault_o)
                | (st_hit & {NPH{shoot_through_mode_sel_i}});
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pump_undervoltage_flag_o <= 1'b1;
        end else if (clear_fault_cmd_i) begin
            pump_undervoltage_flag_o <= 1'b0;
        end
    end

    assign gate_supply_softstart_off_o = gate_supply_softstart_off_i;

    // ****************************************
    // sense amp configuration
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            current_sense_amp_en_o <= 1'b0;
            current_sense_amp_gain_o <= tpg_pkg::CSA_GAIN_RST;
            current_sense_amp_offset_o <= tpg_pkg::CSA_OFS_RST;
        end else if (csa_cfg_we_i) begin
            current_sense_amp_en_o <= csa_enable_set_i;
            if (csa_gain_i <= tpg_pkg::CSA_GAIN_MAX) begin
                current_sense_amp_gain_o <= csa_gain_i;
            end
            current_sense_amp_offset_o <= csa_offset_i;
        end
    end
endmodule
`default_nettype wire

// ---- inc/tpg_pkg.sv ----
`default_nettype none
package tpg_pkg;
    // pwm mode field encodings
    localparam logic [2:0] PWM_MODE_6X = 3'h0;
    localparam logic [2:0] PWM_MODE_3X_PIN = 3'h1;
    localparam logic [2:0] PWM_MODE_3X_REG = 3'h2;
    localparam logic [2:0] PWM_MODE_REG_GATE = 3'h5;
    // six-input dead-time field value that enables input monitoring
    localparam logic [1:0] SIX_DT_MONITOR = 2'h0;
    // sense amp gain settings: nine codes, 0..8
    localparam logic [3:0] CSA_GAIN_MAX = 4'h8;
    localparam logic [3:0] CSA_GAIN_RST = 4'h0;
    // offset select: 0 = half reference, 1 = eighth reference
    localparam logic CSA_OFS_HALF = 1'b0;
    localparam logic CSA_OFS_EIGHTH = 1'b1;
    localparam logic CSA_OFS_RST = CSA_OFS_HALF;
    // timing defaults in ns and derived cycles at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEAD_TIME_NS = 500;
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRONG_PD_NS = 1000;
    localparam int STRONG_PD_CYC = (STRONG_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // phase output states
    typedef enum logic [2:0] {
        TPG_PH_OFF = 3'h1,
        TPG_PH_HIGH = 3'h2,
        TPG_PH_LOW = 3'h4
    } tpg_ph_t;
endpackage
`default_nettype wire

// ---- core/tpg_phase.sv ----
`default_nettype none
// one half-bridge: dead time and strong pull-down timing
module tpg_phase #(
    parameter int CNT_W = tpg_pkg::CNT_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic want_high_i,
    input wire logic want_low_i,
    input wire logic dt_always_i,
    input wire logic [CNT_W-1:0] dead_cyc_i,
    input wire logic [CNT_W-1:0] strong_cyc_i,
    input wire logic kill_i,
    output logic high_gate_out_o,
    output logic low_gate_out_o,
    output logic strong_pd_high_o,
    output logic strong_pd_low_o
);
    // ****************************************
    // dead time state machine
    // ****************************************
    tpg_pkg::tpg_ph_t state_r;
    tpg_pkg::tpg_ph_t state_nxt;
    logic [CNT_W-1:0] off_cnt_r;
    logic [CNT_W-1:0] pd_cnt_r;
    logic pd_on_high_r;
    logic dt_done;

    assign dt_done = (off_cnt_r >= dead_cyc_i);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tpg_pkg::TPG_PH_OFF: begin
                // monitored mode: a long enough both-low gap needs no extra wait
                if (want_high_i && !want_low_i && (dt_done || !dt_always_i && dt_done)) begin
                    state_nxt = tpg_pkg::TPG_PH_HIGH;
                end else if (want_low_i && !want_high_i && dt_done) begin
                    state_nxt = tpg_pkg::TPG_PH_LOW;
                end
            end
            tpg_pkg::TPG_PH_HIGH: begin
                if (!want_high_i || want_low_i) begin
                    state_nxt = tpg_pkg::TPG_PH_OFF;
                end
            end
            tpg_pkg::TPG_PH_LOW: begin
                if (!want_low_i || want_high_i) begin
                    state_nxt = tpg_pkg::TPG_PH_OFF;
                end
            end
            default: state_nxt = tpg_pkg::TPG_PH_OFF;
        endcase
        if (kill_i) begin
            state_nxt = tpg_pkg::TPG_PH_OFF;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= tpg_pkg::TPG_PH_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // both-low gap counter; starts full so first edge is not delayed
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            off_cnt_r <= '1;
        end else if (state_r != tpg_pkg::TPG_PH_OFF) begin
            off_cnt_r <= '0;
        end else if (off_cnt_r != '1) begin
            // counts from gate off; a gap that already covers the dead time adds no wait
            off_cnt_r <= off_cnt_r + 1'b1;
        end
    end

    // ****************************************
    // strong opposite-gate pull-down
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_cnt_r <= '0;
            pd_on_high_r <= 1'b0;
        end else if (state_nxt != state_r && state_nxt != tpg_pkg::TPG_PH_OFF) begin
            pd_cnt_r <= strong_cyc_i;
            pd_on_high_r <= (state_nxt == tpg_pkg::TPG_PH_LOW);
        end else if (state_nxt != state_r && state_r != tpg_pkg::TPG_PH_OFF) begin
            pd_cnt_r <= strong_cyc_i;
            pd_on_high_r <= (state_r == tpg_pkg::TPG_PH_LOW);
        end else if (pd_cnt_r != '0) begin
            pd_cnt_r <= pd_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_gate_out_o <= 1'b0;
            low_gate_out_o <= 1'b0;
            strong_pd_high_o <= 1'b0;
            strong_pd_low_o <= 1'b0;
        end else begin
            high_gate_out_o <= (state_nxt == tpg_pkg::TPG_PH_HIGH);
            low_gate_out_o <= (state_nxt == tpg_pkg::TPG_PH_LOW);
            strong_pd_high_o <= (pd_cnt_r != '0) && pd_on_high_r;
            strong_pd_low_o <= (pd_cnt_r != '0) && !pd_on_high_r;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tpg_assertions.sv ----
`default_nettype none
module tpg_assertions (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] high_side_pwm_in_i,
    input wire logic [2:0] low_side_pwm_in_i,
    input wire logic external_off_pin_i,
    input wire logic sleep_n_i,
    input wire logic fault_i,
    input wire logic [2:0] pwm_mode_i,
    input wire logic shoot_through_mode_sel_i,
    input wire logic [2:0] phase_drive_enable_i,
    input wire logic [7:0] strong_pulldown_time_i,
    input wire logic clear_fault_cmd_i,
    input wire logic csa_cfg_we_i,
    input wire logic [3:0] csa_gain_i,
    input wire logic [2:0] high_gate_out_o,
    input wire logic [2:0] low_gate_out_o,
    input wire logic [2:0] strong_pd_low_o,
    input wire logic [2:0] semi_active_pd_o,
    input wire logic [2:0] shoot_through_fault_o,
    input wire logic pump_undervoltage_flag_o,
    input wire logic current_sense_amp_en_o,
    input wire logic [3:0] current_sense_amp_gain_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!resetn_i);
// **********
// phase 0 events
// **********
sequence s_both_on;
    pwm_mode_i == tpg_pkg::PWM_MODE_6X && shoot_through_mode_sel_i && high_side_pwm_in_i[0] && low_side_pwm_in_i[0];
endsequence
sequence s_high_on;
    $rose(high_gate_out_o[0]) && !$past(external_off_pin_i) && strong_pulldown_time_i != 8'h00;
endsequence
a_off_pin_kill: assert property (external_off_pin_i |-> (high_gate_out_o | low_gate_out_o) == 3'h0)
    else $error("gate on while off pin high");
a_fault_kill: assert property (fault_i |=> (high_gate_out_o | low_gate_out_o) == 3'h0)
    else $error("gate on after fault");
a_st_gates_low: assert property (s_both_on |=> !high_gate_out_o[0] && !low_gate_out_o[0])
    else $error("gate on during cross conduction");
a_st_flag_set: assert property (s_both_on |=> shoot_through_fault_o[0])
    else $error("cross conduction flag missing");
a_no_cross: assert property ((high_gate_out_o & low_gate_out_o) == 3'h0)
    else $error("both gates of a phase on");
a_dead_gap: assert property ($fell(high_gate_out_o[0]) && !external_off_pin_i |-> !low_gate_out_o[0] [*2])
    else $error("dead time missing");
a_pd_opposite: assert property (s_high_on |=> strong_pd_low_o[0])
    else $error("strong pulldown missing");
a_flag_sticky: assert property (shoot_through_fault_o[0] && !clear_fault_cmd_i |=> shoot_through_fault_o[0])
    else $error("fault flag lost");
a_pump_sticky: assert property (pump_undervoltage_flag_o && !clear_fault_cmd_i |=> pump_undervoltage_flag_o)
    else $error("pump flag lost");
a_amp_en_hold: assert property (!csa_cfg_we_i |=> $stable(current_sense_amp_en_o))
    else $error("amp enable changed unasked");
a_gain_load: assert property (csa_cfg_we_i && csa_gain_i <= tpg_pkg::CSA_GAIN_MAX
    |=> current_sense_amp_gain_o == $past(csa_gain_i))
    else $error("gain not loaded");
a_drive_en_off: assert property (!phase_drive_enable_i[0] |=> !high_gate_out_o[0] && !low_gate_out_o[0])
    else $error("disabled phase driving");
a_sleep_pd: assert property (!sleep_n_i |-> semi_active_pd_o == 3'h7)
    else $error("sleep pulldown missing");
endmodule
bind tpg_gate_ctrl tpg_assertions tpg_assertions_inst (.*);
`default_nettype wire

// ---- bench/tpg_mcu_model.sv ----
`default_nettype none
module tpg_mcu_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [1:0] gap_i,
    output logic [2:0] hs_o,
    output logic [2:0] ls_o
);
timeunit 1ns;
timeprecision 1ns;
logic [4:0] cnt_r;
initial begin
    cnt_r = 5'h00;
    hs_o = 3'h0;
    ls_o = 3'h0;
end
// **********
// complementary pwm, low side after a gap
// **********
always @(posedge clk_i) begin
    cnt_r <= run_i ? cnt_r + 5'h01 : 5'h00;
    hs_o <= {3{run_i && cnt_r < 5'h08}};
    ls_o <= {3{run_i && cnt_r >= 5'h08 + {3'h0, gap_i} && cnt_r < 5'h1C}};
end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
module testbench;
timeunit 1ns;
timeprecision 1ns;
logic clk_i = 0, resetn_i = 0, off = 0, slp = 1, flt = 0, clr = 0, we = 0, csen = 0, ofs = 0, ss = 0, run = 0;
logic [2:0] hs = 0, ls = 0, en = 0, rh = 0, rl = 0, mode = 0, hg, lg, sap, stf, mhs, mls, eh, el, en_n;
logic [3:0] gain = 0, gain_o;
logic [1:0] gap = 0;
logic pump, ss_o, cen_o, cofs_o;
logic [31:0] seed = 32'h4192;
logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
int num_errors = 0, checked = 0, lo_seen = 0;
always @(posedge clk_i) if (run && lg[0]) lo_seen <= lo_seen + 1;
always #50 clk_i = ~clk_i;
tpg_mcu_model tpg_mcu_model_inst (.clk_i(clk_i), .run_i(run), .gap_i(gap), .hs_o(mhs), .ls_o(mls));
tpg_gate_ctrl #(.DEAD_CYC(3)) tpg_gate_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .high_side_pwm_in_i(run ? mhs : hs), .low_side_pwm_in_i(run ? mls : ls), .external_off_pin_i(off),
    .sleep_n_i(slp), .fault_i(flt), .pwm_mode_i(mode), .shoot_through_mode_sel_i(1'b1),
    .dead_time_mode_sel_i(1'b0), .six_input_dead_time_sel_i(2'h0), .phase_drive_enable_i(en),
    .reg_high_gate_cmd_i(rh), .reg_low_gate_cmd_i(rl), .strong_pulldown_time_i(8'h04),
    .clear_fault_cmd_i(clr), .gate_supply_softstart_off_i(ss), .csa_enable_set_i(csen), .csa_gain_i(gain),
    .csa_offset_i(ofs), .csa_cfg_we_i(we), .high_gate_out_o(hg), .low_gate_out_o(lg), .strong_pd_high_o(),
    .strong_pd_low_o(), .semi_active_pd_o(sap), .shoot_through_fault_o(stf), .pump_undervoltage_flag_o(pump),
    .gate_supply_softstart_off_o(ss_o), .current_sense_amp_en_o(cen_o), .current_sense_amp_gain_o(gain_o),
    .current_sense_amp_offset_o(cofs_o));
// **********
// helpers
// **********
function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
endfunction
function automatic logic [1:0] exp_gate(input logic [2:0] m, input logic h, l, e, gh, gl);
    if (!e) return 2'h0;
    case (m)
        tpg_pkg::PWM_MODE_3X_PIN: return l ? {h, !h} : 2'h0;
        tpg_pkg::PWM_MODE_3X_REG: return {h, !h};
        tpg_pkg::PWM_MODE_REG_GATE: return {gh & !gl, gl & !gh};
        default: return {h & !l, l & !h};
    endcase
endfunction
task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
endtask
task automatic wait_gates(input logic [2:0] h, l);
    for (int i = 0; i < 12 && {hg, lg} !== {h, l}; i++) @(negedge clk_i);
    chk("gates", {2'h0, hg, lg}, {2'h0, h, l});
endtask
task automatic print_verdict;
    if (num_errors == 0 && checked > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
initial begin
    cyc(20000);
    num_errors++;
    print_verdict;
end
// **********
// main sequence
// **********
initial begin
    cyc(8);
    resetn_i <= 1;
    @(negedge clk_i);
    chk("pump", {7'h0, pump}, 8'h01);
    chk("amp", {2'h0, cen_o, cofs_o, gain_o}, 8'h00);
    chk("stflag", {5'h0, stf}, 8'h00);
    @(posedge clk_i);
    ss <= 1;
    clr <= 1;
    @(posedge clk_i);
    clr <= 0;
    @(negedge clk_i);
    chk("pump", {7'h0, pump}, 8'h00);
    chk("softstart", {7'h0, ss_o}, 8'h01);
    for (int g = 0; g < 10; g++) begin
        @(posedge clk_i);
        we <= 1;
        csen <= g[0];
        ofs <= g[1];
        gain <= g[3:0];
        @(posedge clk_i);
        we <= 0;
        @(negedge clk_i);
        chk("amp", {2'h0, cen_o, cofs_o, gain_o}, {2'h0, g[0], g[1], g < 9 ? g[3:0] : 4'h8});
    end
    repeat (150) begin
        seed = lfsr(seed);
        en_n = seed[16:14] | seed[19:17];
        @(posedge clk_i);
        {hs, ls, rh, rl} <= 12'h000;
        mode <= modes[seed[1:0]];
        en <= en_n;
        cyc(5);
        {rl, rh, ls, hs} <= seed[13:2];
        for (int p = 0; p < 3; p++) {eh[p], el[p]} = exp_gate(modes[seed[1:0]], seed[2+p], seed[5+p], en_n[p],
            seed[8+p], seed[11+p]);
        wait_gates(eh, el);
    end
    @(posedge clk_i);
    {mode, en, hs, ls, clr} <= {3'h0, 3'h7, 6'h00, 1'b1};
    cyc(5);
    {hs, ls, clr} <= 7'h24;
    cyc(2);
    @(negedge clk_i);
    chk("st", {2'h0, stf, hg[1], lg[1]}, 8'h08);
    @(posedge clk_i);
    {hs, ls} <= 6'h00;
    cyc(3);
    @(negedge clk_i);
    chk("stheld", {5'h0, stf}, 8'h02);
    clr <= 1;
    cyc(1);
    {clr, hs} <= 4'h5;
    @(negedge clk_i);
    chk("stclr", {5'h0, stf}, 8'h00);
    wait_gates(3'h5, 3'h0);
    @(posedge clk_i);
    off <= 1;
    @(negedge clk_i);
    chk("off", {2'h0, hg, lg}, 8'h00);
    @(posedge clk_i);
    {off, flt} <= 2'h1;
    cyc(1);
    {flt, hs} <= 4'h0;
    @(negedge clk_i);
    chk("fault", {2'h0, hg, lg}, 8'h00);
    @(posedge clk_i);
    slp <= 0;
    cyc(2);
    @(negedge clk_i);
    chk("sleep", {2'h0, sap, hg}, 8'h38);
    @(posedge clk_i);
    slp <= 1;
    for (int k = 0; k < 6; k++) begin
        @(posedge clk_i);
        {run, gap, mode} <= {1'b1, k[1:0], k[2] ? tpg_pkg::PWM_MODE_3X_PIN : tpg_pkg::PWM_MODE_6X};
        cyc(64);
    end
    chk("deadlow", {7'h0, lo_seen != 0}, 8'h01);
    print_verdict;
end
endmodule
`default_nettype wire
